// file: hdl/lpmr_pkg.sv
// Constants and types for the mode register access block.
// Assumes a 100 MHz core clock and a command/address bus already split into rise and fall halves.
package lpmr_pkg;
	localparam int unsigned CLK_MHZ     = 100;
	localparam int unsigned TSI_MS      = 32;
	localparam int unsigned TSI_CYC     = TSI_MS * 1000 * CLK_MHZ;
	localparam int unsigned MRR_CYC     = 2;
	localparam int unsigned BURST_BEATS = 4;

	localparam logic [3:0]  OP_MRW      = 4'h0;
	localparam logic [3:0]  OP_MRR      = 4'h8;

	localparam logic [7:0]  MR_TEMP     = 8'h04;
	localparam logic [7:0]  MR_ZQ       = 8'h0A;
	localparam logic [7:0]  MR_CAL_A    = 8'h20;
	localparam logic [7:0]  MR_CAL_B    = 8'h28;
	localparam logic [7:0]  MR_RST      = 8'h3F;
	localparam logic [63:0] MR_WR_MAP   = 64'h0000_0000_0003_000E;
	localparam logic [7:0]  MR_DEFAULT  = 8'h00;

	localparam logic [3:0]  PAT_A       = 4'h5;
	localparam logic [3:0]  PAT_B       = 4'hC;

	localparam logic [2:0]  TEMP_HOT    = 3'h3;

	localparam logic [7:0]  ZQ_OP_INIT  = 8'hFF;
	localparam logic [7:0]  ZQ_OP_LONG  = 8'hAB;
	localparam logic [7:0]  ZQ_OP_SHORT = 8'h56;
	localparam logic [7:0]  ZQ_OP_RESET = 8'hC3;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_ACTIVE = 3'b001,
		ST_MRR    = 3'b010,
		ST_MRW    = 3'b011,
		ST_INIT   = 3'b100,
		ST_ZQ     = 3'b101
	} lpmr_state_t;

	typedef enum logic [1:0] {
		ZQ_UNCAL = 2'b00,
		ZQ_DEF30 = 2'b01,
		ZQ_CAL15 = 2'b10
	} lpmr_zq_t;

	typedef enum logic [1:0] {
		ZK_INIT  = 2'b00,
		ZK_RESET = 2'b01,
		ZK_LONG  = 2'b10,
		ZK_SHORT = 2'b11
	} lpmr_zqk_t;
endpackage

// file: hdl/lpmr_temp_status.sv
// Temperature status holder: synchronises the sensor code and refreshes it periodically.
// Assumes temp_sense comes from an analog sensor outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module lpmr_temp_status
	import lpmr_pkg::*;
#(
	parameter int unsigned UPDATE_CYC = TSI_CYC
)(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       clk_en,
	input  wire logic [2:0] temp_sense,
	output logic      [2:0] temp_code
);
	localparam int unsigned CNT_W = $clog2(UPDATE_CYC + 1);

	typedef struct packed {
		logic [2:0]       s1;
		logic [2:0]       s2;
		logic [CNT_W-1:0] cnt;
		logic [2:0]       code;
	} lpmr_ts_t;

	lpmr_ts_t s_r;
	lpmr_ts_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.s1 = temp_sense;
		s_nxt.s2 = s_r.s1;
		if (s_r.cnt == '0) begin
			s_nxt.code = s_r.s2;
			s_nxt.cnt = CNT_W'(UPDATE_CYC - 1);
		end else begin
			s_nxt.cnt = s_r.cnt - CNT_W'(1);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign temp_code = s_r.code;

	a_update_bound: assert property (@(posedge clk) disable iff (!resetn)
		s_r.cnt < CNT_W'(UPDATE_CYC))
		else $error("sensor update counter beyond interval");
	a_code_sample: assert property (@(posedge clk) disable iff (!resetn)
		(clk_en && s_r.cnt == '0) |=> (temp_code == $past(s_r.s2)))
		else $error("temperature code not refreshed at interval end");
endmodule
`default_nettype wire

// file: hdl/lpmr_mode_access.sv
// Mode register access logic: decodes read and write commands, returns register and
// calibration data, runs reset and impedance calibration periods.
// Assumes cs_n, ca_rise, ca_fall and banks_active come from logic on clk.
`timescale 1ns/1ps
`default_nettype none
module lpmr_mode_access
	import lpmr_pkg::*;
#(
	parameter int unsigned READ_LAT   = 3,
	parameter int unsigned T_MRW      = 5,
	parameter int unsigned T_INIT4    = 100,
	parameter int unsigned T_ZQINIT   = 100,
	parameter int unsigned T_ZQRESET  = 10,
	parameter int unsigned T_ZQCL     = 40,
	parameter int unsigned T_ZQCS     = 10,
	parameter int unsigned UPDATE_CYC = TSI_CYC
)(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	input  wire logic        cs_n,
	input  wire logic [9:0]  ca_rise,
	input  wire logic [9:0]  ca_fall,
	input  wire logic        banks_active,
	input  wire logic [2:0]  temp_sense,
	output logic      [31:0] dq_rise,
	output logic      [31:0] dq_fall,
	output logic             dq_oe,
	output logic      [2:0]  dev_state,
	output logic      [1:0]  zq_level,
	output logic             zq_init_done
);
	typedef struct packed {
		lpmr_state_t state;
		logic [15:0] cnt;
		logic        ret_act;
		logic        rd_pend;
		logic [3:0]  lat;
		logic [7:0]  baddr;
		logic [7:0]  rdata;
		logic        beat;
		logic        dq_oe;
		logic [31:0] dq_rise;
		logic [31:0] dq_fall;
		lpmr_zqk_t   zq_kind;
		lpmr_zq_t    zq_level;
		logic        zq_done;
	} lpmr_st_t;

	lpmr_st_t   s_r;
	lpmr_st_t   s_nxt;
	logic [7:0] mr_mem [64];
	logic [7:0] cmd_addr;
	logic [7:0] cmd_data;
	logic       mrr_go;
	logic       mrw_go;
	logic       mem_we;
	logic       mem_clr;
	logic [2:0] temp_code;

	lpmr_temp_status #(
		.UPDATE_CYC (UPDATE_CYC)
	) u_temp (
		.clk        (clk),
		.resetn     (resetn),
		.clk_en     (clk_en),
		.temp_sense (temp_sense),
		.temp_code  (temp_code)
	);

	function automatic logic [7:0] mr_addr(input logic [9:0] r, input logic [9:0] f);
		mr_addr = {f[1:0], r[9:4]};
	endfunction

	function automatic logic is_writable(input logic [7:0] a);
		is_writable = (a[7:6] == 2'h0) && MR_WR_MAP[a[5:0]];
	endfunction

	function automatic logic [31:0] beat_data(input logic [7:0] a, input logic [7:0] d,
			input logic [1:0] t);
		if (a == MR_CAL_A) begin
			beat_data = {32{PAT_A[t]}};
		end else if (a == MR_CAL_B) begin
			beat_data = {32{PAT_B[t]}};
		end else begin
			beat_data = (t == 2'h0) ? {24'h000000, d} : 32'h00000000;
		end
	endfunction

	assign cmd_addr = mr_addr(ca_rise, ca_fall);
	assign cmd_data = ca_fall[9:2];
	assign mrr_go   = !cs_n && (ca_rise[3:0] == OP_MRR) && !s_r.rd_pend &&
	                  (s_r.state == ST_IDLE || s_r.state == ST_ACTIVE);
	assign mrw_go   = !cs_n && (ca_rise[3:0] == OP_MRW) &&
	                  (s_r.state == ST_IDLE) && !banks_active;

	always_comb begin
		s_nxt = s_r;
		mem_we = 1'h0;
		mem_clr = 1'h0;
		s_nxt.dq_oe = 1'h0;
		s_nxt.dq_rise = 32'h00000000;
		s_nxt.dq_fall = 32'h00000000;
		// Read burst: two beats per clock, four beats in all
		if (s_r.rd_pend && s_r.lat == 4'h0) begin
			s_nxt.rd_pend = 1'h0;
			s_nxt.dq_oe = 1'h1;
			s_nxt.beat = 1'h0;
			s_nxt.dq_rise = beat_data(s_r.baddr, s_r.rdata, 2'h0);
			s_nxt.dq_fall = beat_data(s_r.baddr, s_r.rdata, 2'h1);
		end else if (s_r.rd_pend) begin
			s_nxt.lat = s_r.lat - 4'h1;
		end else if (s_r.dq_oe && !s_r.beat) begin
			s_nxt.dq_oe = 1'h1;
			s_nxt.beat = 1'h1;
			s_nxt.dq_rise = beat_data(s_r.baddr, s_r.rdata, 2'h2);
			s_nxt.dq_fall = beat_data(s_r.baddr, s_r.rdata, 2'h3);
		end
		case (s_r.state)
			ST_IDLE, ST_ACTIVE: begin
				s_nxt.state = banks_active ? ST_ACTIVE : ST_IDLE;
				if (mrr_go) begin
					s_nxt.state = ST_MRR;
					s_nxt.cnt = 16'(MRR_CYC - 1);
					s_nxt.ret_act = (s_r.state == ST_ACTIVE);
					s_nxt.rd_pend = 1'h1;
					s_nxt.lat = 4'(READ_LAT - 1);
					s_nxt.baddr = cmd_addr;
					if (cmd_addr == MR_TEMP) begin
						s_nxt.rdata = {5'h00, temp_code};
					end else if (is_writable(cmd_addr)) begin
						s_nxt.rdata = mr_mem[cmd_addr[5:0]];
					end else begin
						s_nxt.rdata = 8'h00;
					end
				end else if (mrw_go && cmd_addr == MR_RST) begin
					s_nxt.state = ST_INIT;
					s_nxt.cnt = 16'(T_INIT4 - 1);
					mem_clr = 1'h1;
				end else if (mrw_go && cmd_addr == MR_ZQ &&
						(cmd_data == ZQ_OP_INIT || cmd_data == ZQ_OP_RESET ||
						cmd_data == ZQ_OP_LONG || cmd_data == ZQ_OP_SHORT)) begin
					s_nxt.state = ST_ZQ;
					if (cmd_data == ZQ_OP_INIT) begin
						s_nxt.zq_kind = ZK_INIT;
						s_nxt.cnt = 16'(T_ZQINIT - 1);
					end else if (cmd_data == ZQ_OP_RESET) begin
						s_nxt.zq_kind = ZK_RESET;
						s_nxt.cnt = 16'(T_ZQRESET - 1);
					end else if (cmd_data == ZQ_OP_LONG) begin
						s_nxt.zq_kind = ZK_LONG;
						s_nxt.cnt = 16'(T_ZQCL - 1);
					end else begin
						s_nxt.zq_kind = ZK_SHORT;
						s_nxt.cnt = 16'(T_ZQCS - 1);
					end
				end else if (mrw_go) begin
					s_nxt.state = ST_MRW;
					s_nxt.cnt = 16'(T_MRW - 1);
					mem_we = is_writable(cmd_addr);
				end
			end
			ST_MRR, ST_MRW, ST_INIT, ST_ZQ: begin
				if (s_r.cnt != 16'h0000) begin
					s_nxt.cnt = s_r.cnt - 16'h0001;
				end else begin
					s_nxt.state = (s_r.state == ST_MRR && s_r.ret_act) ? ST_ACTIVE : ST_IDLE;
					if (s_r.state == ST_ZQ) begin
						case (s_r.zq_kind)
							ZK_INIT: begin
								s_nxt.zq_level = ZQ_CAL15;
								s_nxt.zq_done = 1'h1;
							end
							ZK_LONG: begin
								s_nxt.zq_level = ZQ_CAL15;
							end
							ZK_RESET: begin
								s_nxt.zq_level = ZQ_DEF30;
							end
							default: begin
								s_nxt.zq_level = s_r.zq_level;
							end
						endcase
					end
				end
			end
			default: begin
				s_nxt.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 64; i++) begin
				mr_mem[i] <= MR_DEFAULT;
			end
		end else if (clk_en) begin
			if (mem_clr) begin
				for (int i = 0; i < 64; i++) begin
					mr_mem[i] <= MR_DEFAULT;
				end
			end else if (mem_we) begin
				mr_mem[cmd_addr[5:0]] <= cmd_data;
			end
		end
	end

	assign dq_rise      = s_r.dq_rise;
	assign dq_fall      = s_r.dq_fall;
	assign dq_oe        = s_r.dq_oe;
	assign dev_state    = s_r.state;
	assign zq_level     = s_r.zq_level;
	assign zq_init_done = s_r.zq_done;

	a_mrw_store: assert property (@(posedge clk) disable iff (!resetn)
		(clk_en && mem_we) |=> (mr_mem[$past(cmd_addr[5:0])] == $past(cmd_data)))
		else $error("writable register not updated by write");
	a_ro_write_ignored: assert property (@(posedge clk) disable iff (!resetn)
		(mrw_go && !is_writable(cmd_addr)) |-> !mem_we)
		else $error("read-only register write enabled storage");
	a_mrr_period: assert property (@(posedge clk) disable iff (!resetn)
		(clk_en && mrr_go) ##1 clk_en ##1 clk_en |=> (dev_state != ST_MRR))
		else $error("read period not two clocks");
	a_mrr_return: assert property (@(posedge clk) disable iff (!resetn)
		(clk_en && dev_state == ST_MRR && s_r.cnt == 16'h0000 && s_r.ret_act)
		|=> (dev_state == ST_ACTIVE))
		else $error("read did not return to bank active state");
	a_cal_pattern: assert property (@(posedge clk) disable iff (!resetn)
		(dq_oe && s_r.baddr == MR_CAL_A) |->
		(dq_rise == {32{PAT_A[{s_r.beat, 1'h0}]}}) && (dq_fall == {32{PAT_A[{s_r.beat, 1'h1}]}}))
		else $error("calibration pattern A wrong");
	a_first_beat: assert property (@(posedge clk) disable iff (!resetn)
		(dq_oe && !s_r.beat && s_r.baddr != MR_CAL_A && s_r.baddr != MR_CAL_B)
		|-> (dq_rise[7:0] == s_r.rdata))
		else $error("register data missing on first beat");
	a_temp_read: assert property (@(posedge clk) disable iff (!resetn)
		(clk_en && mrr_go && cmd_addr == MR_TEMP) |=> (s_r.rdata == {5'h00, $past(temp_code)}))
		else $error("temperature status not returned");
	a_reset_entry: assert property (@(posedge clk) disable iff (!resetn)
		(clk_en && mrw_go && cmd_addr == MR_RST) |=> (dev_state == ST_INIT && mr_mem[1] == MR_DEFAULT))
		else $error("reset write did not restore defaults");
	a_zq_reset_level: assert property (@(posedge clk) disable iff (!resetn)
		(clk_en && dev_state == ST_ZQ && s_r.cnt == 16'h0000 && s_r.zq_kind == ZK_RESET)
		|=> (zq_level == ZQ_DEF30))
		else $error("calibration reset did not restore defaults");
	a_rd_latency: assert property (@(posedge clk) disable iff (!resetn)
		(clk_en && mrr_go) ##1 (clk_en && !dq_oe)[*3] |=> dq_oe)
		else $error("read burst not at read latency");

	c_cal_read: cover property (@(posedge clk) disable iff (!resetn)
		dq_oe && s_r.baddr == MR_CAL_B);
	c_reset: cover property (@(posedge clk) disable iff (!resetn)
		dev_state == ST_INIT);
	c_zq_long: cover property (@(posedge clk) disable iff (!resetn)
		dev_state == ST_ZQ && s_r.zq_kind == ZK_LONG);
	c_active_read: cover property (@(posedge clk) disable iff (!resetn)
		dev_state == ST_MRR && s_r.ret_act);
endmodule
`default_nettype wire

// file: bench/lpmr_host.sv
// Host controller model: puts register read and write commands on the command bus.
// Assumes the bench waits for each command to finish before it asks for the next one.
`timescale 1ns/1ps
`default_nettype none
module lpmr_host
	import lpmr_pkg::*;
(
	input  wire logic       clk,
	output logic            cs_n,
	output logic      [9:0] ca_rise,
	output logic      [9:0] ca_fall
);
	initial begin
		cs_n = 1'b1;
		ca_rise = 10'h000;
		ca_fall = 10'h000;
	end
	// Never issues array bursts or a polling loop
	task automatic cmd(input logic [3:0] op, input logic [7:0] adr, input logic [7:0] dat);
		@(posedge clk);
		cs_n <= 1'b0;
		ca_rise <= {adr[5:0], op};
		ca_fall <= {dat, adr[7:6]};
		@(posedge clk);
		// Deselected: lines show the inverse of the last value
		cs_n <= 1'b1;
		ca_rise <= ~{adr[5:0], op};
		ca_fall <= ~{dat, adr[7:6]};
	endtask
endmodule
`default_nettype wire

// file: bench/lpddr2_mode_register_access_tb_top.sv
// Bench for the mode register access block driven by the host model.
// Assumes short period parameters so the run stays brief.
`timescale 1ns/1ps
`default_nettype none
module lpddr2_mode_register_access_tb_top
	import lpmr_pkg::*;
;
	localparam int RL = 3;
	localparam int TMRW = 5;
	localparam int TINIT = 20;
	localparam int UPD = 16;
	localparam int TZQI = 30;
	localparam int TZQR = 6;
	localparam int TZQL = 12;
	localparam int TZQS = 4;
	logic        clk;
	logic        resetn;
	logic        clk_en;
	logic        cs_n;
	logic [9:0]  ca_rise;
	logic [9:0]  ca_fall;
	logic        banks_active;
	logic [2:0]  temp_sense;
	logic [31:0] dq_rise;
	logic [31:0] dq_fall;
	logic        dq_oe;
	logic [2:0]  dev_state;
	logic [1:0]  zq_level;
	logic        zq_init_done;
	int          n_mismatch;
	int          check_count;

	lpmr_host u_lpmr_host (.clk(clk), .cs_n(cs_n), .ca_rise(ca_rise), .ca_fall(ca_fall));
	lpmr_mode_access #(.READ_LAT(RL), .T_MRW(TMRW), .T_INIT4(TINIT), .T_ZQINIT(TZQI),
		.T_ZQRESET(TZQR), .T_ZQCL(TZQL), .T_ZQCS(TZQS), .UPDATE_CYC(UPD)) u_lpmr_mode_access (
		.clk(clk), .resetn(resetn), .clk_en(clk_en), .cs_n(cs_n), .ca_rise(ca_rise),
		.ca_fall(ca_fall), .banks_active(banks_active), .temp_sense(temp_sense),
		.dq_rise(dq_rise), .dq_fall(dq_fall), .dq_oe(dq_oe), .dev_state(dev_state),
		.zq_level(zq_level), .zq_init_done(zq_init_done));

	always #5 clk = ~clk;

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic timeout();
		n_mismatch++;
		$display("unexpected at %0t: wait ran out", $time);
		results();
	endtask
	// Register read: both beat pairs, then output enable drops
	task automatic rd(input logic [7:0] adr, input logic [31:0] r0, input logic [31:0] f0,
		input logic [31:0] r1, input logic [31:0] f1);
		int k;
		u_lpmr_host.cmd(OP_MRR, adr, 8'h00);
		#1;
		chk({29'h0, dev_state}, {29'h0, ST_MRR});
		for (k = 0; k <= RL && dq_oe !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		if (dq_oe !== 1'b1) timeout();
		chk(k, RL);
		chk(dq_rise, r0);
		chk(dq_fall, f0);
		@(posedge clk);
		#1;
		chk(dq_rise, r1);
		chk(dq_fall, f1);
		@(posedge clk);
		#1;
		chk({31'h0, dq_oe}, 32'h0);
	endtask
	task automatic rdr(input logic [7:0] adr, input logic [7:0] val);
		rd(adr, {24'h0, val}, 32'h0, 32'h0, 32'h0);
	endtask
	// Counts the cycles spent in a busy state
	task automatic wr(input logic [7:0] adr, input logic [7:0] dat, input logic [2:0] code,
		input int len);
		int n = 0;
		int k;
		u_lpmr_host.cmd(OP_MRW, adr, dat);
		#1;
		for (k = 0; k < 400; k++) begin
			if (dev_state === code) n++;
			else if (n > 0) break;
			@(posedge clk);
			#1;
		end
		if (k == 400) timeout();
		chk(n, len);
	endtask
	task automatic t_reset();
		chk({29'h0, dev_state}, {29'h0, ST_IDLE});
		chk({27'h0, zq_level, 1'b0, dq_oe, zq_init_done}, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_write();
		wr(8'h01, 8'hA5, ST_MRW, TMRW);
		wr(8'h10, 8'h3C, ST_MRW, TMRW);
		wr(MR_TEMP, 8'hFF, ST_MRW, TMRW);
		wr(8'h41, 8'h5A, ST_MRW, TMRW);
		rdr(8'h01, 8'hA5);
		rdr(8'h10, 8'h3C);
		rdr(8'h41, 8'h00);
		$display("write test done");
	endtask
	// Clock enable low holds the write period where it stands
	task automatic t_freeze();
		u_lpmr_host.cmd(OP_MRW, 8'h02, 8'h3C);
		clk_en <= 1'b0;
		repeat (10) @(posedge clk);
		clk_en <= 1'b1;
		#1;
		chk({29'h0, dev_state}, {29'h0, ST_MRW});
		repeat (TMRW - 1) @(posedge clk);
		#1;
		chk({29'h0, dev_state}, {29'h0, ST_MRW});
		@(posedge clk);
		#1;
		chk({29'h0, dev_state}, {29'h0, ST_IDLE});
		rdr(8'h02, 8'h3C);
		$display("clock enable test done");
	endtask
	task automatic t_temp();
		@(posedge clk);
		temp_sense <= TEMP_HOT;
		repeat (UPD + 6) @(posedge clk);
		rdr(MR_TEMP, {5'h0, TEMP_HOT});
		@(posedge clk);
		temp_sense <= 3'h5;
		repeat (UPD + 6) @(posedge clk);
		rdr(MR_TEMP, 8'h05);
		$display("temperature test done");
	endtask
	// Issued from idle
	task automatic t_cal();
		rd(MR_CAL_A, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF, 32'h0);
		rd(MR_CAL_B, 32'h0, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF);
		$display("calibration pattern test done");
	endtask
	task automatic t_active();
		@(posedge clk);
		banks_active <= 1'b1;
		@(posedge clk);
		u_lpmr_host.cmd(OP_MRW, 8'h10, 8'h77);
		repeat (TMRW) @(posedge clk);
		#1;
		chk({29'h0, dev_state}, {29'h0, ST_ACTIVE});
		rdr(8'h10, 8'h3C);
		chk({29'h0, dev_state}, {29'h0, ST_ACTIVE});
		@(posedge clk);
		banks_active <= 1'b0;
		repeat (2) @(posedge clk);
		$display("bank active test done");
	endtask
	task automatic t_zq();
		logic [7:0] op [4] = '{ZQ_OP_INIT, ZQ_OP_RESET, ZQ_OP_SHORT, ZQ_OP_LONG};
		int tm [4] = '{TZQI, TZQR, TZQS, TZQL};
		logic [1:0] lv [4] = '{ZQ_CAL15, ZQ_DEF30, ZQ_DEF30, ZQ_CAL15};
		for (int i = 0; i < 4; i++) begin
			wr(MR_ZQ, op[i], ST_ZQ, tm[i]);
			chk({30'h0, zq_level}, {30'h0, lv[i]});
			chk({31'h0, zq_init_done}, 32'h1);
		end
		wr(MR_ZQ, 8'h12, ST_MRW, TMRW);
		$display("impedance calibration test done");
	endtask
	task automatic t_mrw_reset();
		wr(MR_RST, 8'h00, ST_INIT, TINIT);
		rdr(8'h01, MR_DEFAULT);
		rdr(8'h10, MR_DEFAULT);
		chk({30'h0, zq_level}, {30'h0, ZQ_CAL15});
		$display("reset command test done");
	endtask

	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		clk_en = 1'b1;
		banks_active = 1'b0;
		temp_sense = 3'h0;
		n_mismatch = 0;
		check_count = 0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		#1;
		t_reset();
		t_write();
		t_freeze();
		t_temp();
		t_cal();
		t_active();
		t_zq();
		t_mrw_reset();
		results();
	end
endmodule
`default_nettype wire
